// ==== ctd_defines.vh ====
// Constants shared by the current tamper detector files
`ifndef CTD_DEFINES_VH
`define CTD_DEFINES_VH
`define CTD_OFS_CTRL 5'h00
`define CTD_OFS_STATUS 5'h04
`define CTD_OFS_IRQ_STATUS 5'h08
`define CTD_OFS_IRQ_CLEAR 5'h0C
`define CTD_OFS_IRQ_ENABLE 5'h10
`define CTD_CTRL_ENABLE 0
`define CTD_CTRL_THRESHOLD 1
`define CTD_CTRL_STANDALONE 2
`define CTD_CTRL_PINFUNC_LO 4
`define CTD_CTRL_PINFUNC_HI 5
`define CTD_CTRL_RESET 32'h00000001
`define CTD_IRQ_ENTER 0
`define CTD_IRQ_LEAVE 1
`define CTD_IRQ_SWAP 2
`define CTD_IRQ_EVAL 3
`define CTD_PERIODS_CYCLE 6'h3F
`define CTD_PER_SWITCH 6'h18
`define CTD_PER_B_START 6'h1C
`define CTD_PER_A_START 6'h20
`define CTD_PER_A_END 6'h23
`define CTD_PER_HOLD_END 6'h28
`define CTD_AGREE_NEEDED 3'h4
`define CTD_SHIFT_12P5 3'h4
`define CTD_SHIFT_6P25 3'h5
`endif

// ==== ctd_threshold_select_eval.v ====
// Tamper criterion evaluation on two captured channel energies
`timescale 1ns/100ps
`default_nettype none
`include "ctd_defines.vh"
module ctd_threshold_select_eval #(
    parameter AW = 32
) (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire evalStrobe,
    input wire thresholdSelect,
    input wire signed [AW-1:0] energyA,
    input wire signed [AW-1:0] energyB,
    output reg critMet_ff,
    output reg oppositeSign_ff,
    output reg higherSecondary_ff,
    output reg evalDone_ff
);
    function [AW-1:0] absVal;
        input [AW-1:0] v;
        begin
            absVal = v[AW-1] ? (~v + {{(AW-1){1'b0}}, 1'b1}) : v;
        end
    endfunction

    wire [AW-1:0] magA;
    wire [AW-1:0] magB;
    wire [AW:0] magSum;
    wire [AW-1:0] magDiff;
    wire [AW+5:0] scaledDiff;
    wire opposite;
    assign magA = absVal(energyA);
    assign magB = absVal(energyB);
    assign magSum = {1'b0, magA} + {1'b0, magB};
    assign magDiff = (magA > magB) ? (magA - magB) : (magB - magA);
    // |A-B| > K*(A+B)/2 becomes |A-B| << (4 or 5) > (A+B), no divider needed
    assign scaledDiff = {6'h00, magDiff} << (thresholdSelect ? `CTD_SHIFT_6P25 : `CTD_SHIFT_12P5);
    assign opposite = energyA[AW-1] ^ energyB[AW-1];

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            critMet_ff <= 1'b0;
            oppositeSign_ff <= 1'b0;
            higherSecondary_ff <= 1'b0;
            evalDone_ff <= 1'b0;
        end else if (ce) begin
            evalDone_ff <= evalStrobe;
            if (evalStrobe) begin
                critMet_ff <= opposite | (scaledDiff > {5'h00, magSum});
                oppositeSign_ff <= opposite;
                higherSecondary_ff <= magB > magA;
            end
        end
    end
endmodule
`default_nettype wire

// ==== ctd_tamper.v ====
// Current tamper detector: line-period sequencer, sample capture, state and registers
// Functional notes
// - Tamper mode time-shares one current modulator between primary and secondary channel.
// - Tamper criterion: |A-B| above 12.5% or 6.25% of average, chosen by threshold_select.
// - Opposite-sign samples keep tamper flag on; larger magnitude still picks channel.
// - Single wire metering compares apparent energy instead of active energy.
// - Period error, stuck modulator stream or no load force normal state, evaluation off.
// - Reset starts in normal state with primary channel integrated.
// - Checking sequence repeats every sixty-four line periods.
// - Period 24 switches to secondary and holds primary values for sixteen periods.
// - Secondary integrates four periods after hold, then primary returns and integrates.
// - Secondary sample then primary sample are evaluated; higher current gives candidate.
// - Four consecutive agreeing results are needed before the state changes, except opposite sign, which enters tamper at once.
// - Tamper state multiplexes 56:8 toward primary if larger, else 8:56.
// - Status flag shows tamper; standalone mode also drives it to serial data pin.
// - No load suspends power integration and disables the tamper logic.
// - Peripheral mode, pin function 1: pulse pin shows selected channel.
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "ctd_defines.vh"
module ctd_tamper #(
    parameter PW = 24,
    parameter AW = 32
) (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire lineCycleEvent,
    input wire lineFrequencyError,
    input wire sdStreamStuck,
    input wire noLoadFlag,
    input wire singleWireMetering,
    input wire powerStrobe,
    input wire signed [PW-1:0] activePower,
    input wire signed [PW-1:0] apparentPower,
    output reg channelSelect,
    output reg holdPrimaryValues,
    output reg integrateSecondary,
    output wire powerIntegrateEn,
    output reg tamperFlag,
    output reg serialDataPin,
    output reg energyPulsePin,
    output wire irq
);
    reg [31:0] ctrl_ff;
    reg [3:0] irqStatus_ff;
    reg [3:0] irqEnable_ff;
    reg ack_ff;
    reg [5:0] period_ff;
    reg selSecondary_ff;
    reg tamper_ff;
    reg [2:0] agree_ff;
    reg candTamper_ff;
    reg candSecondary_ff;
    reg signed [AW-1:0] accA_ff;
    reg signed [AW-1:0] accB_ff;
    reg evalPending_ff;
    reg [5:0] nxt_period;
    reg nxt_selSecondary;
    reg nxt_tamper;
    reg [2:0] nxt_agree;
    reg nxt_candTamper;
    reg nxt_candSecondary;
    reg [3:0] events;
    wire active;
    wire inSwitch;
    wire inHold;
    wire inSlotB;
    wire inSlotA;
    wire evalStrobe;
    wire critMet;
    wire oppositeSign;
    wire higherSecondary;
    wire evalDone;
    wire measSecondary;
    wire signed [PW-1:0] comparedPower;
    wire signed [AW-1:0] powerExt;
    wire [1:0] pinFunc;
    wire [31:0] beMask;
    wire wrTaken;
    wire rdTaken;

    function inRange;
        input [5:0] v;
        input [5:0] lo;
        input [5:0] hi;
        begin
            inRange = (v >= lo) && (v <= hi);
        end
    endfunction

    assign pinFunc = ctrl_ff[`CTD_CTRL_PINFUNC_HI:`CTD_CTRL_PINFUNC_LO];
    // Any bad input kills the sequence rather than letting a stale sample decide
    assign active = ctrl_ff[`CTD_CTRL_ENABLE] & ~lineFrequencyError & ~sdStreamStuck & ~noLoadFlag;
    assign powerIntegrateEn = ~noLoadFlag;
    assign inSwitch = inRange(period_ff, `CTD_PER_SWITCH, `CTD_PER_A_START - 6'h01);
    assign inHold = inRange(period_ff, `CTD_PER_SWITCH, `CTD_PER_HOLD_END - 6'h01);
    assign inSlotB = inRange(period_ff, `CTD_PER_B_START, `CTD_PER_A_START - 6'h01);
    assign inSlotA = inRange(period_ff, `CTD_PER_A_START, `CTD_PER_A_END);
    // One cycle after the last slot A period (period 35), so its final power sample is in the sum
    assign evalStrobe = active & evalPending_ff;
    // Channel actually on the modulator: selected one, swapped during the switch window
    assign measSecondary = selSecondary_ff ^ inSwitch;
    assign comparedPower = singleWireMetering ? apparentPower : activePower;
    assign powerExt = {{(AW-PW){comparedPower[PW-1]}}, comparedPower};

    ctd_threshold_select_eval #(
        .AW(AW)
    ) u_threshold_select (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .evalStrobe(evalStrobe),
        .thresholdSelect(ctrl_ff[`CTD_CTRL_THRESHOLD]),
        .energyA(accA_ff),
        .energyB(accB_ff),
        .critMet_ff(critMet),
        .oppositeSign_ff(oppositeSign),
        .higherSecondary_ff(higherSecondary),
        .evalDone_ff(evalDone)
    );

    // Period counter and sample accumulators
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            period_ff <= 6'h00;
            evalPending_ff <= 1'b0;
            accA_ff <= {AW{1'b0}};
            accB_ff <= {AW{1'b0}};
        end else if (ce) begin
            period_ff <= nxt_period;
            evalPending_ff <= active & lineCycleEvent & (period_ff == `CTD_PER_A_END);
            if (!active) begin
                accA_ff <= {AW{1'b0}};
                accB_ff <= {AW{1'b0}};
            end else if (lineCycleEvent && period_ff == `CTD_PER_SWITCH) begin
                accA_ff <= {AW{1'b0}};
                accB_ff <= {AW{1'b0}};
            end else if (powerStrobe) begin
                // Samples are filed by physical channel, so mirrored cycles, sampling A then B, still fill the right sums
                if (inSlotB && measSecondary)
                    accB_ff <= accB_ff + powerExt;
                if (inSlotB && !measSecondary)
                    accA_ff <= accA_ff + powerExt;
                if (inSlotA && measSecondary)
                    accB_ff <= accB_ff + powerExt;
                if (inSlotA && !measSecondary)
                    accA_ff <= accA_ff + powerExt;
            end
        end
    end

    always @* begin
        nxt_period = period_ff;
        if (!active)
            nxt_period = 6'h00;
        else if (lineCycleEvent)
            nxt_period = (period_ff == `CTD_PERIODS_CYCLE) ? 6'h00 : period_ff + 6'h01;
    end

    // Candidate tracking and state decision
    always @* begin
        nxt_selSecondary = selSecondary_ff;
        nxt_tamper = tamper_ff;
        nxt_agree = agree_ff;
        nxt_candTamper = candTamper_ff;
        nxt_candSecondary = candSecondary_ff;
        events = 4'h0;
        if (!active) begin
            nxt_selSecondary = 1'b0;
            nxt_tamper = 1'b0;
            nxt_agree = 3'h0;
            nxt_candTamper = 1'b0;
            nxt_candSecondary = 1'b0;
        end else if (evalDone) begin
            events[`CTD_IRQ_EVAL] = 1'b1;
            nxt_candTamper = critMet;
            nxt_candSecondary = critMet & higherSecondary;
            if (agree_ff != 3'h0 && critMet == candTamper_ff && (critMet & higherSecondary) == candSecondary_ff)
                nxt_agree = (agree_ff == `CTD_AGREE_NEEDED) ? agree_ff : agree_ff + 3'h1;
            else
                nxt_agree = 3'h1;
            if (oppositeSign)
                nxt_tamper = 1'b1;
            if (nxt_agree == `CTD_AGREE_NEEDED) begin
                nxt_tamper = critMet;
                nxt_selSecondary = critMet & higherSecondary;
            end
        end
        if (nxt_tamper && !tamper_ff)
            events[`CTD_IRQ_ENTER] = 1'b1;
        if (!nxt_tamper && tamper_ff)
            events[`CTD_IRQ_LEAVE] = 1'b1;
        if (nxt_selSecondary != selSecondary_ff)
            events[`CTD_IRQ_SWAP] = 1'b1;
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            selSecondary_ff <= 1'b0;
            tamper_ff <= 1'b0;
            agree_ff <= 3'h0;
            candTamper_ff <= 1'b0;
            candSecondary_ff <= 1'b0;
        end else if (ce) begin
            selSecondary_ff <= nxt_selSecondary;
            tamper_ff <= nxt_tamper;
            agree_ff <= nxt_agree;
            candTamper_ff <= nxt_candTamper;
            candSecondary_ff <= nxt_candSecondary;
        end
    end

    // Pin outputs from flip-flops
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            channelSelect <= 1'b0;
            holdPrimaryValues <= 1'b0;
            integrateSecondary <= 1'b0;
            tamperFlag <= 1'b0;
            serialDataPin <= 1'b0;
            energyPulsePin <= 1'b0;
        end else if (ce) begin
            channelSelect <= active & (nxt_selSecondary ^ inRange(nxt_period, `CTD_PER_SWITCH,
                `CTD_PER_A_START - 6'h01));
            holdPrimaryValues <= active & inRange(nxt_period, `CTD_PER_SWITCH, `CTD_PER_HOLD_END - 6'h01);
            integrateSecondary <= nxt_selSecondary;
            tamperFlag <= nxt_tamper;
            serialDataPin <= ctrl_ff[`CTD_CTRL_STANDALONE] & nxt_tamper;
            // Other pin functions live outside this block, so the pin rests low there
            energyPulsePin <= ~ctrl_ff[`CTD_CTRL_STANDALONE] & (pinFunc == 2'h1) & nxt_selSecondary;
        end
    end

    // Avalon-MM slave: one wait state, then the access completes
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign wrTaken = avs_write & ack_ff;
    assign rdTaken = avs_read & ~ack_ff;
    assign beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign irq = |(irqStatus_ff & irqEnable_ff);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_ff <= 1'b0;
            avs_readdata <= 32'h00000000;
            ctrl_ff <= `CTD_CTRL_RESET;
            irqStatus_ff <= 4'h0;
            irqEnable_ff <= 4'h0;
        end else if (ce) begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
            if (rdTaken) begin
                case (avs_address)
                    `CTD_OFS_CTRL: avs_readdata <= ctrl_ff & 32'h00000037;
                    `CTD_OFS_STATUS: avs_readdata <= {17'h00000, agree_ff, period_ff, 2'h0,
                        holdPrimaryValues, channelSelect, selSecondary_ff, tamper_ff};
                    `CTD_OFS_IRQ_STATUS: avs_readdata <= {28'h0000000, irqStatus_ff};
                    `CTD_OFS_IRQ_ENABLE: avs_readdata <= {28'h0000000, irqEnable_ff};
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
            if (wrTaken && avs_address == `CTD_OFS_CTRL)
                ctrl_ff <= ((ctrl_ff & ~beMask) | (avs_writedata & beMask)) & 32'h00000037;
            if (wrTaken && avs_address == `CTD_OFS_IRQ_ENABLE && avs_byteenable[0])
                irqEnable_ff <= avs_writedata[3:0];
            // A new event in the clearing cycle survives the clear
            if (wrTaken && avs_address == `CTD_OFS_IRQ_CLEAR && avs_byteenable[0])
                irqStatus_ff <= (irqStatus_ff & ~avs_writedata[3:0]) | events;
            else
                irqStatus_ff <= irqStatus_ff | events;
        end
    end
endmodule
`default_nettype wire

// ==== ctd_tamper_chk.sv ====
// Port-level assertions for the current tamper detector
`timescale 1ns/100ps
`default_nettype none
module ctd_tamper_chk (
    input wire clk,
    input wire rstn,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire lineCycleEvent,
    input wire lineFrequencyError,
    input wire sdStreamStuck,
    input wire noLoadFlag,
    input wire channelSelect,
    input wire holdPrimaryValues,
    input wire integrateSecondary,
    input wire powerIntegrateEn,
    input wire tamperFlag,
    input wire serialDataPin,
    input wire energyPulsePin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire req = avs_read | avs_write;
    wire fault = lineFrequencyError | sdStreamStuck | noLoadFlag;
    wire swap = channelSelect ^ integrateSecondary;
    logic [4:0] holdCnt_ff;
    logic [4:0] swapCnt_ff;
    // Events counted only while a window is open, so lengths are in line periods
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            holdCnt_ff <= 5'h00;
            swapCnt_ff <= 5'h00;
        end else begin
            holdCnt_ff <= holdPrimaryValues ? holdCnt_ff + 5'(lineCycleEvent) : 5'h00;
            swapCnt_ff <= swap ? swapCnt_ff + 5'(lineCycleEvent) : 5'h00;
        end
    end
    a_wait_state: assert property (req && !$past(req) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus wait state not exactly one");
    a_noload_en: assert property (powerIntegrateEn == !noLoadFlag)
        else $error("integration enable ignores no load");
    a_fault_normal: assert property (fault |=> !tamperFlag && !holdPrimaryValues &&
        !channelSelect && !integrateSecondary)
        else $error("fault did not force normal state");
    a_hold_len: assert property ($fell(holdPrimaryValues) && !$past(fault) && !$past(fault, 2) |->
        holdCnt_ff == 5'h10)
        else $error("hold window not sixteen periods");
    a_swap_len: assert property ($fell(swap) && swapCnt_ff != 5'h00 && !$past(fault) |-> swapCnt_ff == 5'h08)
        else $error("other channel window not eight periods");
    a_hold_cause: assert property ($rose(holdPrimaryValues) |-> $past(lineCycleEvent))
        else $error("hold rose without line event");
    a_reset_normal: assert property ($rose(rstn) |-> !tamperFlag && !integrateSecondary && !channelSelect)
        else $error("not normal after reset");
    a_serial_flag: assert property (serialDataPin |-> tamperFlag || $past(tamperFlag))
        else $error("serial pin high without tamper");
    a_pulse_pin: assert property (energyPulsePin |-> integrateSecondary || $past(integrateSecondary))
        else $error("pulse pin high with primary selected");
endmodule
bind ctd_tamper ctd_tamper_chk i_ctd_tamper_chk (.clk(clk), .rstn(rstn), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .lineCycleEvent(lineCycleEvent),
    .lineFrequencyError(lineFrequencyError), .sdStreamStuck(sdStreamStuck), .noLoadFlag(noLoadFlag),
    .channelSelect(channelSelect), .holdPrimaryValues(holdPrimaryValues),
    .integrateSecondary(integrateSecondary), .powerIntegrateEn(powerIntegrateEn),
    .tamperFlag(tamperFlag), .serialDataPin(serialDataPin), .energyPulsePin(energyPulsePin));
`default_nettype wire

// ==== ctd_partner.sv ====
// Energy datapath model: line events and power samples of the channel on the modulator
`timescale 1ns/100ps
`default_nettype none
module ctd_partner #(
    parameter int PER = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic channelSelect,
    input wire logic signed [23:0] pwrA,
    input wire logic signed [23:0] pwrB,
    input wire logic signed [23:0] appA,
    input wire logic signed [23:0] appB,
    output logic lineCycleEvent,
    output logic powerStrobe,
    output logic signed [23:0] activePower,
    output logic signed [23:0] apparentPower
);
    logic [7:0] div_ff;
    // Short line period keeps a 64 period sequence cheap to simulate
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_ff <= 8'h00;
            lineCycleEvent <= 1'b0;
            powerStrobe <= 1'b0;
        end else begin
            div_ff <= (div_ff == 8'(PER - 1)) ? 8'h00 : div_ff + 8'h01;
            lineCycleEvent <= (div_ff == 8'(PER - 1));
            powerStrobe <= 1'b1;
        end
    end
    // One modulator: samples come from whichever channel is switched in
    assign activePower = channelSelect ? pwrB : pwrA;
    assign apparentPower = channelSelect ? appB : appA;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the current tamper detector
`timescale 1ns/100ps
`default_nettype none
`include "ctd_defines.vh"
`define CHK(n, e, v) begin n_checks++; if ((v) !== (e)) begin failures++; \
    $display("ERROR %s exp %0h got %0h", n, e, v); end end
module tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, lineCycleEvent, powerStrobe, channelSelect, holdPrimaryValues, integrateSecondary;
    logic powerIntegrateEn, tamperFlag, serialDataPin, energyPulsePin, irq;
    logic [2:0] fault = 3'h0;
    logic singleWireMetering = 1'b0;
    logic signed [23:0] pwrA = 24'sd100, pwrB = 24'sd100, appA = 24'sd100, appB = 24'sd100;
    logic signed [23:0] activePower, apparentPower;
    int failures = 0, n_checks = 0, cyc = 0;
    always #2.5 clk = ~clk;
    ctd_tamper i_ctd_tamper (.clk(clk), .rstn(rstn), .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .lineCycleEvent(lineCycleEvent), .lineFrequencyError(fault[0]),
        .sdStreamStuck(fault[1]), .noLoadFlag(fault[2]), .singleWireMetering(singleWireMetering),
        .powerStrobe(powerStrobe), .activePower(activePower), .apparentPower(apparentPower),
        .channelSelect(channelSelect), .holdPrimaryValues(holdPrimaryValues), .integrateSecondary(integrateSecondary),
        .powerIntegrateEn(powerIntegrateEn), .tamperFlag(tamperFlag), .serialDataPin(serialDataPin),
        .energyPulsePin(energyPulsePin), .irq(irq));
    ctd_partner i_ctd_partner (.clk(clk), .rstn(rstn), .channelSelect(channelSelect), .pwrA(pwrA), .pwrB(pwrB),
        .appA(appA), .appB(appB), .lineCycleEvent(lineCycleEvent), .powerStrobe(powerStrobe),
        .activePower(activePower), .apparentPower(apparentPower));
    task stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task per(input int n);
        repeat (n) @(posedge clk iff lineCycleEvent);
        @(posedge clk);
        #1;
    endtask
    // Each fault source alone must drop any tamper state; also realigns the sequence
    task t_fault;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            fault <= 3'h1 << i;
            repeat (2) @(posedge clk);
            #1;
            `CHK("tamper", 1'b0, tamperFlag);
            `CHK("chan", 1'b0, integrateSecondary);
            `CHK("hold", 1'b0, holdPrimaryValues);
            `CHK("mux", 1'b0, channelSelect);
            `CHK("integ", (i != 2), powerIntegrateEn);
            @(posedge clk);
            fault <= 3'h0;
        end
    endtask
    task t_regs;
        bus(0, `CTD_OFS_CTRL, 0);
        `CHK("ctrl", 32'h00000001, rd);
        bus(0, `CTD_OFS_STATUS, 0);
        `CHK("status", 4'h0, rd[3:0]);
        bus(0, 5'h14, 0);
        `CHK("unmapped", 32'h0, rd);
        bus(1, `CTD_OFS_IRQ_ENABLE, 32'hFF);
        bus(0, `CTD_OFS_IRQ_ENABLE, 0);
        `CHK("irqen", 32'h0000000F, rd);
        bus(0, `CTD_OFS_IRQ_CLEAR, 0);
        `CHK("irqclr", 32'h0, rd);
    endtask
    task t_thresh;
        int n;
        @(posedge clk);
        pwrB <= 24'sd110;
        bus(1, `CTD_OFS_IRQ_ENABLE, 32'h1);
        t_fault;
        per(240);
        `CHK("below", 1'b0, tamperFlag);
        bus(1, `CTD_OFS_CTRL, 32'h3);
        t_fault;
        per(226);
        `CHK("three", 1'b0, tamperFlag);
        per(4);
        `CHK("four", 1'b1, tamperFlag);
        `CHK("higher", 1'b1, integrateSecondary);
        `CHK("irq", 1'b1, irq);
        bus(1, `CTD_OFS_IRQ_CLEAR, 32'hF);
        per(0);
        `CHK("irqclr", 1'b0, irq);
        n = 0;
        repeat (64) begin
            @(posedge clk iff lineCycleEvent);
            if (channelSelect === 1'b0) n++;
        end
        `CHK("ratio", 8, n);
        bus(1, `CTD_OFS_CTRL, 32'h7);
        per(0);
        `CHK("sdata", 1'b1, serialDataPin);
        bus(1, `CTD_OFS_CTRL, 32'h13);
        per(0);
        `CHK("pulse", 1'b1, energyPulsePin);
        `CHK("sdoff", 1'b0, serialDataPin);
    endtask
    task t_sign;
        @(posedge clk);
        pwrB <= -24'sd200;
        bus(1, `CTD_OFS_CTRL, 32'h1);
        t_fault;
        per(40);
        `CHK("sign", 1'b1, tamperFlag);
        `CHK("early", 1'b0, integrateSecondary);
        per(192);
        `CHK("bigger", 1'b1, integrateSecondary);
    endtask
    task t_swm;
        @(posedge clk);
        pwrB <= 24'sd100;
        appB <= 24'sd150;
        singleWireMetering <= 1'b1;
        t_fault;
        per(232);
        `CHK("swm", 1'b1, tamperFlag);
        `CHK("swmch", 1'b1, integrateSecondary);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            stop_test;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_thresh;
        t_sign;
        t_swm;
        stop_test;
    end
endmodule
`default_nettype wire
